// ==== bench/comparator_model.sv ====
`timescale 1ns/1ps
// Analog comparators and host enables; levels in millivolts
module comparator_model #(
    parameter int ARM_HI_MV = 1100, // Arming threshold
    parameter int ARM_LO_MV = 1000, // Disarm threshold
    parameter int STB_MV    = 200,  // Standby plus hysteresis, arbitrary
    parameter int PON_MV    = 800   // Power-on level, arbitrary
) (
    input  wire logic [2:0]  en,       // Host enables
    input  wire logic [11:0] ss_mv [3], // Soft start levels
    input  wire logic [2:0]  sw_low,   // Switch node below limit
    input  wire logic [2:0]  ea_high,  // Error amp above window
    input  wire logic [2:0]  ea_low,   // Error amp below window
    input  wire logic [2:0]  fb_under, // Feedback undervoltage
    output fault_pkg::chan_cmp_t cmp [fault_pkg::NCH] // To sequencer
);
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            cmp[i].enable     = en[i];
            cmp[i].ss_arm_hi  = ss_mv[i] > ARM_HI_MV;
            cmp[i].ss_arm_lo  = ss_mv[i] < ARM_LO_MV;
            cmp[i].ss_standby = ss_mv[i] > STB_MV;
            cmp[i].ss_pon     = ss_mv[i] > PON_MV;
            cmp[i].sw_low     = sw_low[i];
            cmp[i].ea_high    = ea_high[i];
            cmp[i].ea_low     = ea_low[i];
            cmp[i].fb_under   = fb_under[i];
        end
    end
endmodule

// ==== bench/fault_offlatch_sequencer_test.sv ====
`timescale 1ns/1ps
module fault_offlatch_sequencer_test;
    logic clk = 0, sys_rst = 1, tr_flt = 0, uv = 0, model_lat = 0;
    logic [2:0] en = 0, f_sw = 0, f_eh = 0, f_el = 0, f_fb = 0;
    logic [2:0] hs, run;
    logic [11:0] ss [3] = '{default: 12'h000};
    logic req [3] = '{default: 1'b0};
    logic flag_o, flag_oe_n, offlatch;
    fault_pkg::chan_cmp_t cmp_in [fault_pkg::NCH];
    int fail_count = 0, total_checks = 0, cycles = 0, ch;
    int seed = 32'h353a05f2;

    always #25 clk = ~clk;

    comparator_model u_comparator_model (.en(en), .ss_mv(ss),
        .sw_low(f_sw), .ea_high(f_eh), .ea_low(f_el), .fb_under(f_fb),
        .cmp(cmp_in));

    fault_offlatch_sequencer u_fault_offlatch_sequencer (.clk(clk),
        .sys_rst(sys_rst), .cmp_in(cmp_in), .sw_on_request(req),
        .timing_resistor_pin_fault(tr_flt), .supply_uv(uv),
        .high_side_on(hs), .chan_run(run), .fault_latch_flag_o(flag_o),
        .fault_latch_flag_oe_n(flag_oe_n), .offlatch(offlatch));

    task automatic end_sim;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // Ceiling well above the roughly 57k cycles the tests need
    always @(posedge clk) begin
        cycles++;
        if (cycles == 90000) begin
            fail_count++;
            $display("[FAIL] %0t run hung", $time);
            end_sim;
        end
    end

    task automatic cmp3(input logic [2:0] got, input logic [2:0] exp);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %0t got %b expected %b", $time, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    // Latch state, flag pin and channel permission against the model
    task automatic chk;
        @(negedge clk);
        cmp3({offlatch, flag_oe_n, flag_o},
             {model_lat, !model_lat, 1'b0});
        cmp3(run, model_lat ? 3'b000 : en);
    endtask

    task automatic set_flt(input int k, input int c, input logic v);
        @(posedge clk);
        case (k)
            0: f_sw[c] <= v;
            1: f_eh[c] <= v;
            2: f_el[c] <= v;
            3: f_fb[c] <= v;
            default: tr_flt <= v;
        endcase
    endtask

    task automatic power(input logic v);
        @(posedge clk);
        en <= {3{v}};
        for (int i = 0; i < 3; i++)
            ss[i] <= v ? 12'h5dc : 12'h000;
        cyc(20);
    endtask

    // Sync plus 8000-cycle filter: quiet just before, latched just after
    task automatic trip(input int k, input logic armed);
        ch = $unsigned($random(seed)) % 3;
        set_flt(k, ch, 1'b1);
        cyc(7990);
        chk;
        cyc(40);
        model_lat = armed;
        chk;
        set_flt(k, ch, 1'b0);
    endtask

    task automatic rel_uv;
        @(posedge clk);
        uv <= 1'b1;
        cyc(10);
        model_lat = 0;
        chk;
        @(posedge clk);
        uv <= 1'b0;
        power(1'b0);
        power(1'b1);
    endtask

    logic [5:0] r;
    initial begin
        cyc(20);
        sys_rst <= 1'b0;
        chk;
        power(1'b1);
        chk;
        repeat (20) begin
            @(posedge clk);
            r = 6'($random(seed));
            for (int i = 0; i < 3; i++)
                req[i] <= r[i];
            f_sw <= r[5:3];
            @(negedge clk);
            cmp3(hs, r[2:0] & ~r[5:3]);
        end
        @(posedge clk);
        f_sw <= 3'b000;
        $display("test high side done");
        // Short overcurrent on every channel must leave no count behind
        @(posedge clk);
        f_sw <= 3'b111;
        cyc(4000);
        f_sw <= 3'b000;
        cyc(10);
        chk;
        trip(0, 1'b1);
        @(negedge clk);
        cmp3(hs, 3'b000);
        @(posedge clk);
        en <= 3'b000;
        cyc(3990);
        chk;
        cyc(40);
        model_lat = 0;
        chk;
        power(1'b1);
        chk;
        $display("test overcurrent done");
        for (int k = 1; k < 4; k++) begin
            trip(k, 1'b1);
            rel_uv;
        end
        $display("test window done");
        @(posedge clk);
        for (int i = 0; i < 3; i++)
            ss[i] <= 12'h1f4;
        cyc(10);
        trip(1, 1'b0);
        trip(4, 1'b1);
        rel_uv;
        $display("test gating done");
        end_sim;
    end
endmodule

// ==== rtl/fault_offlatch_sequencer.sv ====
`timescale 1ns/1ps
// Contract
// - Switch off at once on low switch node
// - Overcurrent latches after 400 us persistence
// - Error amp out of window latches
// - Window check armed above soft start threshold
// - Timing resistor fault latches all channels
// - Timing resistor check always active
// - Timing resistor fault needs 400 us
// - Soft start timeout 50 ms latches
// - Any protection latches until release
// - Enables all low 200 us release
// - Supply undervoltage releases latch
// - After release enables accepted again
// - Flag pin low while latched
// - Feedback undervoltage latches after 400 us
module fault_offlatch_sequencer (
    input  wire logic                clk,                  // 20 MHz clock
    input  wire logic                sys_rst,              // Sync reset
    input  wire fault_pkg::chan_cmp_t cmp_in [fault_pkg::NCH], // Comparators
    input  wire logic                sw_on_request [fault_pkg::NCH], // PWM on
    input  wire logic                timing_resistor_pin_fault, // Open/short
    input  wire logic                supply_uv,            // Supply below 4.5 V
    output logic [fault_pkg::NCH-1:0] high_side_on,        // Gate drive
    output logic [fault_pkg::NCH-1:0] chan_run,            // Channel allowed
    output logic                     fault_latch_flag_o,   // Flag pin data
    output logic                     fault_latch_flag_oe_n, // Low drives
    output logic                     offlatch              // Latch state
);
    typedef enum logic [1:0] {
        CH_OFF   = 2'b00,
        CH_START = 2'b01,
        CH_ON    = 2'b11
    } ch_state_t;

    // Soft start and steady run both count as a started channel
    function automatic logic ch_active(input ch_state_t s);
        return s != CH_OFF;
    endfunction

    localparam int SW = fault_pkg::CMP_W * fault_pkg::NCH;

    logic [SW-1:0] raw_flat;
    logic [SW-1:0] syn_flat;
    logic [1:0]    misc_syn;
    logic          rt_fault;
    logic          uv_s;
    logic [2:0]    sw_req_s;
    fault_pkg::chan_cmp_t cs [fault_pkg::NCH];

    logic [fault_pkg::NCH-1:0] ocp_armed_r;
    logic [fault_pkg::NCH-1:0] win_armed_r;
    logic [fault_pkg::NCH-1:0] ocp_exp;
    logic [fault_pkg::NCH-1:0] win_exp;
    logic [fault_pkg::NCH-1:0] lvp_exp;
    logic [fault_pkg::NCH-1:0] tmo_hit;
    logic [fault_pkg::NCH-1:0] en_vec;
    logic                      rt_exp;
    logic                      rel_exp;
    logic                      trip;
    logic                      offlatch_r;
    ch_state_t                 st_r [fault_pkg::NCH];
    logic [fault_pkg::SS_W-1:0] ss_cnt_r [fault_pkg::NCH];

    // Pin-level comparators all cross into the clock domain
    always_comb begin
        for (int c = 0; c < fault_pkg::NCH; c++) begin
            raw_flat[c*fault_pkg::CMP_W +: fault_pkg::CMP_W] = cmp_in[c];
        end
    end

    sync3 #(.W(SW)) u_sync_ch (
        .clk     (clk),
        .sys_rst (sys_rst),
        .din     (raw_flat),
        .dout    (syn_flat)
    );

    // Timing resistor monitor and supply monitor are analog levels too
    sync3 #(.W(2)) u_sync_misc (
        .clk     (clk),
        .sys_rst (sys_rst),
        .din     ({timing_resistor_pin_fault, supply_uv}),
        .dout    (misc_syn)
    );

    assign rt_fault = misc_syn[1];
    assign uv_s     = misc_syn[0];

    // Cycle-by-cycle current limit stays combinational: a synchroniser
    // delay would let the switch conduct four more cycles
    generate
        for (genvar c = 0; c < fault_pkg::NCH; c++) begin : g_ch
            assign cs[c] = fault_pkg::chan_cmp_t'(
                syn_flat[c*fault_pkg::CMP_W +: fault_pkg::CMP_W]);
            assign en_vec[c] = cs[c].enable;
            assign sw_req_s[c] = sw_on_request[c];

            assign high_side_on[c] = sw_req_s[c] && chan_run[c]
                && !cmp_in[c].sw_low;

            // Hysteretic arming on soft start
            always_ff @(posedge clk) begin
                if (sys_rst || !cs[c].enable || cs[c].ss_arm_lo) begin
                    ocp_armed_r[c] <= 1'b0;
                    win_armed_r[c] <= 1'b0;
                end else if (cs[c].ss_arm_hi && ch_active(st_r[c])) begin
                    ocp_armed_r[c] <= 1'b1;
                    win_armed_r[c] <= 1'b1;
                end
            end

            // Any dropout of a qualified level restarts its filter
            persist_filt #(.LIMIT(fault_pkg::FILT_CYC)) u_ocp (
                .clk     (clk),
                .sys_rst (sys_rst),
                .cond    (ocp_armed_r[c] && cs[c].sw_low),
                .expired (ocp_exp[c])
            );

            persist_filt #(.LIMIT(fault_pkg::FILT_CYC)) u_win (
                .clk     (clk),
                .sys_rst (sys_rst),
                .cond    (win_armed_r[c]
                          && (cs[c].ea_high || cs[c].ea_low)),
                .expired (win_exp[c])
            );

            persist_filt #(.LIMIT(fault_pkg::FILT_CYC)) u_lvp (
                .clk     (clk),
                .sys_rst (sys_rst),
                .cond    (win_armed_r[c] && cs[c].fb_under),
                .expired (lvp_exp[c])
            );

            // Channel sequence; start only accepted while unlatched
            always_ff @(posedge clk) begin
                if (sys_rst) begin
                    st_r[c] <= CH_OFF;
                end else begin
                    unique case (st_r[c])
                        CH_OFF: begin
                            if (cs[c].enable && !offlatch_r) begin
                                st_r[c] <= CH_START;
                            end
                        end
                        CH_START: begin
                            if (!cs[c].enable || offlatch_r) begin
                                st_r[c] <= CH_OFF;
                            end else if (cs[c].ss_pon) begin
                                st_r[c] <= CH_ON;
                            end
                        end
                        CH_ON: begin
                            if (!cs[c].enable || offlatch_r) begin
                                st_r[c] <= CH_OFF;
                            end
                        end
                        default: st_r[c] <= CH_OFF;
                    endcase
                end
            end

            // Timeout counts from soft start leaving standby
            always_ff @(posedge clk) begin
                if (sys_rst || st_r[c] != CH_START) begin
                    ss_cnt_r[c] <= '0;
                end else if (cs[c].ss_standby
                             && ss_cnt_r[c] !=
                             fault_pkg::SS_W'(fault_pkg::SS_TMO_CYC)) begin
                    ss_cnt_r[c] <= ss_cnt_r[c] + 1'b1;
                end
            end

            assign tmo_hit[c] = st_r[c] == CH_START && !cs[c].ss_pon
                && ss_cnt_r[c] ==
                fault_pkg::SS_W'(fault_pkg::SS_TMO_CYC);

            assign chan_run[c] = ch_active(st_r[c]) && !offlatch_r;
        end
    endgenerate

    persist_filt #(.LIMIT(fault_pkg::FILT_CYC)) u_rt (
        .clk     (clk),
        .sys_rst (sys_rst),
        .cond    (rt_fault),
        .expired (rt_exp)
    );

    // While all enables stay low the release stays expired and keeps
    // overriding any trip, the timing resistor one included
    persist_filt #(.LIMIT(fault_pkg::REL_CYC)) u_rel (
        .clk     (clk),
        .sys_rst (sys_rst),
        .cond    (en_vec == '0),
        .expired (rel_exp)
    );

    assign trip = rt_exp || (|ocp_exp) || (|win_exp) || (|lvp_exp)
        || (|tmo_hit);

    // Release beats a new trip: with supply gone nothing can be trusted
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            offlatch_r <= 1'b0;
        end else if (uv_s || rel_exp) begin
            offlatch_r <= 1'b0;
        end else if (trip) begin
            offlatch_r <= 1'b1;
        end
    end

    assign offlatch              = offlatch_r;
    assign fault_latch_flag_o    = 1'b0;
    assign fault_latch_flag_oe_n = !offlatch_r;

    // Per-channel checks watch channel 0, the c_on cover channel 1; the channels are built alike
    a_trip_latches : assert property
        (@(posedge clk) disable iff (sys_rst)
        trip && !uv_s && !rel_exp |=> offlatch_r)
        else $error("trip did not latch");

    a_latch_holds : assert property
        (@(posedge clk) disable iff (sys_rst)
        offlatch_r && !uv_s && !rel_exp |=> offlatch_r)
        else $error("latch dropped without release");

    a_uv_release : assert property
        (@(posedge clk) disable iff (sys_rst)
        uv_s |=> !offlatch_r)
        else $error("undervoltage did not release");

    a_rel_clears : assert property
        (@(posedge clk) disable iff (sys_rst)
        rel_exp |=> !offlatch_r)
        else $error("enable release did not clear latch");

    a_flag_drive : assert property
        (@(posedge clk) disable iff (sys_rst)
        fault_latch_flag_oe_n == !offlatch_r)
        else $error("flag pin mismatch");

    a_rel_needs_low : assert property
        (@(posedge clk) disable iff (sys_rst)
        $fell(offlatch_r) && !$past(uv_s) |-> $past(en_vec) == '0)
        else $error("release with enable high");

    a_sw_off : assert property
        (@(posedge clk) disable iff (sys_rst)
        cmp_in[0].sw_low |-> !high_side_on[0])
        else $error("switch stayed on");

    a_rt_trip : assert property
        (@(posedge clk) disable iff (sys_rst)
        rt_exp && !uv_s && !rel_exp |=> offlatch_r ##0 !chan_run[0])
        else $error("timing fault did not latch");

    a_run_blocked : assert property
        (@(posedge clk) disable iff (sys_rst)
        offlatch_r |-> chan_run == '0)
        else $error("channel ran while latched");

    a_latch_stops : assert property
        (@(posedge clk) disable iff (sys_rst)
        offlatch_r |=> st_r[0] == CH_OFF)
        else $error("channel sequence not stopped by latch");

    a_start_ok : assert property
        (@(posedge clk) disable iff (sys_rst)
        !offlatch_r && st_r[0] == CH_OFF && cs[0].enable
        |=> st_r[0] == CH_START)
        else $error("enable ignored after release");

    a_arm_gate : assert property
        (@(posedge clk) disable iff (sys_rst)
        !cs[0].enable |=> !ocp_armed_r[0])
        else $error("armed with enable low");

    a_arm_needs_hi : assert property
        (@(posedge clk) disable iff (sys_rst)
        $rose(ocp_armed_r[0]) |-> $past(cs[0].ss_arm_hi))
        else $error("armed below soft start threshold");

    a_win_disarm : assert property
        (@(posedge clk) disable iff (sys_rst)
        cs[0].ss_arm_lo |=> !win_armed_r[0])
        else $error("window check armed below soft start threshold");

    // The full timeout lies far beyond a test run, so its counter is
    // checked step by step instead
    a_tmo_clear : assert property
        (@(posedge clk) disable iff (sys_rst)
        st_r[0] != CH_START |=> ss_cnt_r[0] == '0)
        else $error("timeout count not cleared");

    a_tmo_count : assert property
        (@(posedge clk) disable iff (sys_rst)
        st_r[0] == CH_START && cs[0].ss_standby
        && ss_cnt_r[0] != fault_pkg::SS_W'(fault_pkg::SS_TMO_CYC)
        |=> ss_cnt_r[0] == $past(ss_cnt_r[0]) + 1'b1)
        else $error("timeout count stalled");

    c_latch : cover property (@(posedge clk) $rose(offlatch_r));
    c_release : cover property (@(posedge clk) $fell(offlatch_r) && !uv_s);
    c_tmo : cover property (@(posedge clk) tmo_hit[0]);
    c_on : cover property (@(posedge clk) st_r[1] == CH_ON);
    c_win_trip : cover property (@(posedge clk) |win_exp);
endmodule

// ==== rtl/fault_pkg.sv ====
package fault_pkg;
    localparam int NCH = 3;
    localparam int CLK_HZ = 20000000;
    // Persistence and release times, as printed
    localparam int FILT_US = 400;
    localparam int REL_US = 200;
    localparam int SS_TMO_MS = 50;
    localparam int FILT_CYC = (FILT_US * (CLK_HZ / 1000000));
    localparam int REL_CYC = (REL_US * (CLK_HZ / 1000000));
    localparam int SS_TMO_CYC = (SS_TMO_MS * (CLK_HZ / 1000));
    localparam int CNT_W = 20;
    localparam int SS_W = 21;
    localparam int SYNC_DEPTH = 3;

    // Synchronised comparator levels of one channel
    typedef struct packed {
        logic enable;     // channel enable high
        logic ss_arm_hi;  // soft start above upper arming threshold
        logic ss_arm_lo;  // soft start below lower disarm threshold
        logic ss_standby; // soft start above standby threshold + hyst
        logic ss_pon;     // soft start above power-on threshold
        logic sw_low;     // switch node below current limit reference
        logic ea_high;    // error amp above upper window
        logic ea_low;     // error amp below lower window
        logic fb_under;   // feedback below undervoltage level
    } chan_cmp_t;

    localparam int CMP_W = $bits(chan_cmp_t);
endpackage

// ==== rtl/persist_filt.sv ====
`timescale 1ns/1ps
// Fires once a level has stood continuously for LIMIT cycles
module persist_filt #(
    parameter int LIMIT = 8000
) (
    input  wire logic clk,     // System clock
    input  wire logic sys_rst, // Synchronous reset
    input  wire logic cond,    // Qualified fault level
    output logic      expired  // High while condition has persisted
);
    logic [fault_pkg::CNT_W-1:0] cnt_r;

    always_ff @(posedge clk) begin
        if (sys_rst || !cond) begin
            cnt_r <= '0;
        end else if (cnt_r != fault_pkg::CNT_W'(LIMIT)) begin
            cnt_r <= cnt_r + 1'b1;
        end
    end

    assign expired = cond && (cnt_r == fault_pkg::CNT_W'(LIMIT));

    a_filt_restart : assert property (@(posedge clk) disable iff (sys_rst)
        !cond |=> cnt_r == '0)
        else $error("filter did not restart");
endmodule

// ==== rtl/sync3.sv ====
`timescale 1ns/1ps
// Three-stage synchroniser; a change is taken once stages two and three agree
module sync3 #(
    parameter int W = 1
) (
    input  wire logic         clk,     // System clock
    input  wire logic         sys_rst, // Synchronous reset
    input  wire logic [W-1:0] din,     // Asynchronous levels
    output logic      [W-1:0] dout     // Filtered levels
);
    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
        end else begin
            s1_r <= din;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // Hold the last agreed value while stages disagree
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            dout <= '0;
        end else begin
            for (int i = 0; i < W; i++) begin
                if (s2_r[i] == s3_r[i]) begin
                    dout[i] <= s3_r[i];
                end
            end
        end
    end
endmodule
